/* cpsd_pkg.sv */
/*
 * Shared constants for the charger power-up and source detect block:
 * register offsets, field positions, reset values, result codes and
 * timing counts.
 * Assumes a 25 MHz pclk and APB register access with 32-bit data.
 */
package cpsd_pkg;

    // Clock and time units
    localparam int CLK_MHZ = 25;
    localparam int T_TICK_US = 1000;
    localparam int TICK_CYC = T_TICK_US * CLK_MHZ;
    localparam int T_BIAS_REGULATOR_MS = 220;
    localparam int T_BADSRC_MS = 30;
    localparam int T_RETRY_MS = 2000;
    localparam int T_DCD_MS = 500;
    localparam int T_HVHS_MS = 40;
    localparam int T_INT_NS = 100000;
    localparam int INT_CYC = (T_INT_NS * CLK_MHZ) / 1000;

    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] LIMIT_PIN_ADDR = 8'h04;
    localparam logic [7:0] VLIM_ADDR = 8'h08;
    localparam logic [7:0] STAT_ADDR = 8'h0c;
    localparam logic [7:0] EFF_ADDR = 8'h10;

    // Control register fields
    localparam int C_AUTO = 0;
    localparam int C_FORCE = 1;
    localparam int C_HVA = 2;
    localparam int C_HVB = 3;
    localparam int C_HIZ = 4;
    localparam int C_FABS = 5;
    localparam int C_REQ12 = 6;
    localparam int C_SELPIN = 7;
    localparam logic [7:0] CTRL_RST = 8'h0d;

    // Status register fields above the 3-bit source type
    localparam int S_IGOOD = 3;
    localparam int S_PGOOD = 4;
    localparam int S_DSTAT = 5;
    localparam int S_BATDIS = 6;
    localparam int S_HIZST = 7;
    localparam int S_BIAS = 8;
    localparam int S_CONV = 9;

    // Current limits in 50 mA units, voltage limit in 100 mV units
    localparam logic [6:0] LIMIT_PIN_RST = 7'h0a;
    localparam logic [6:0] LIM_500MA = 7'h0a;
    localparam logic [6:0] LIM_1A = 7'h14;
    localparam logic [6:0] LIM_1A5 = 7'h1e;
    localparam logic [6:0] LIM_2A = 7'h28;
    localparam logic [6:0] LIM_2A1 = 7'h2a;
    localparam logic [6:0] LIM_2A4 = 7'h30;
    localparam logic [6:0] LIM_3A25 = 7'h41;
    localparam logic [7:0] VLIM_RST = 8'h2c;
    localparam logic [7:0] VLIM_MIN = 8'h27;
    localparam logic [7:0] VLIM_MAX = 8'h8c;

    // Source type codes
    localparam logic [2:0] TYP_NONE = 3'h0;
    localparam logic [2:0] TYP_SDP = 3'h1;
    localparam logic [2:0] TYP_CDP = 3'h2;
    localparam logic [2:0] TYP_DCP = 3'h3;
    localparam logic [2:0] TYP_HV = 3'h4;
    localparam logic [2:0] TYP_UNK = 3'h5;
    localparam logic [2:0] TYP_DIV = 3'h6;

    typedef enum logic [2:0] {
        ST_HIZ, ST_BIAS_REGULATOR, ST_QUAL, ST_RETRY, ST_DETECT, ST_HANDSHAKE,
        ST_VLIM, ST_RUN
    } cpsd_state_type;

endpackage : cpsd_pkg

/* cpsd_core.sv */
/*
 * Power-up sequencer and input source detection of a one-cell charger,
 * with its APB register file and host interrupt pulse.
 * Assumes presetn is the power-on reset, analog comparator levels
 * arrive asynchronously, and limit_pin_code and vlim_auto come from
 * logic on pclk.
 */
// Notes on behaviour
// - Power-on reset returns every register to default; bus ready after it.
// - Battery alone above depletion: battery switch on, bias regulator off.
// - Battery overcurrent: switch off at once, flag set until input or exit.
// - Attach order: bias, qualify, detect type, voltage limit, converter.
// - Bias needs input above UVLO, sleep condition per mode, 220 ms wait.
// - Any bias condition lost: high impedance state, regulator off.
// - Source passes if below overvoltage and above minimum under 30mA load.
// - Passing source sets input-good flag and pulses the interrupt.
// - Failed qualification is retried every 2 seconds.
// - Type detection follows input-good and bias, only if auto or force bit set.
// - Auto detection off: limit, type and status bit stay unchanged.
// - Detection done: interrupt, load limit, power-good flag; pin low only in select-pin mode.
// - Host may rewrite the limit; effective limit is min with limit pin.
// - Start standard detection; after 500ms contact timeout, non-standard.
// - Four divider windows give 2.1A, 2A, 1A and 2.4A.
// - High-voltage handshake after DCP only while an enable bit is set.
// - 12 V: sink on D+, source on D-; 9 V the opposite.
// - Detection sets type code and limit, always sets the status bit.
// - Select pin: high gives 500mA type 001, low gives 3.25A type 010.
// - Force bit reruns detection and clears itself when done.
// - Voltage limit covers 3.9 V to 14 V, set by one of two methods.
// - Force-absolute set: host writes the limit; clear: algorithm owns it.
// - Voltage limit set: interrupt pulse queued in the same cycle the converter starts.
`timescale 1ns/1ns
`default_nettype none
module cpsd_core
    import cpsd_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply comparators
    input wire logic vbus_uvlo_ok,
    input wire logic vbus_sleep_ok,
    input wire logic vbus_boost_sleep_ok,
    input wire logic boost_mode,
    input wire logic bat_above_dpl,
    input wire logic bat_ocp,
    input wire logic ship_exit,
    input wire logic vbus_ovp_ok,
    input wire logic vbus_min_ok,
    // D+/D- and select pin comparators
    input wire logic dcd_contact,
    input wire logic primary_det,
    input wire logic secondary_det,
    input wire logic dp_2p7,
    input wire logic dp_2p0,
    input wire logic dp_1p2,
    input wire logic dm_2p7,
    input wire logic dm_2p0,
    input wire logic dm_1p2,
    input wire logic select_pin,
    // On-chip limit sources
    input wire logic [6:0] limit_pin_code,
    input wire logic [7:0] vlim_auto,
    // Power path controls
    output logic bias_regulator_en,
    output logic battery_switch_on,
    output logic test_load_en,
    output logic converter_en,
    output logic dp_sink_en,
    output logic dp_src_en,
    output logic dm_sink_en,
    output logic dm_src_en,
    output logic [6:0] eff_current_limit,
    output logic [7:0] input_voltage_limit,
    // Host pins
    output logic int_n,
    output logic power_good_pin_n
);

    localparam int NSYNC = 19;

    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic uvlo_ok, sleep_ok, bsleep_ok, boost, bat_dpl, ocp, ship;
    logic ovp_ok, min_ok, dcd, prim, sec, psel_pin;
    logic [2:0] dpw, dmw;
    logic uvlo_prev_q;
    logic [14:0] tick_cnt_q;
    logic tick;
    logic [10:0] ms_q;
    cpsd_state_type st_q, st_d;
    logic bias_cond;
    logic qual_pass, qual_fail, det_done, vlim_set;
    logic [2:0] det_type;
    logic [6:0] det_lim;
    logic [7:0] ctrl_q;
    logic [6:0] limit_pin_q;
    logic [7:0] vlim_q;
    logic [2:0] src_type_q;
    logic input_good_q, power_good_q, det_stat_q, bat_dis_q;
    logic wr, rd_setup;
    logic [1:0] pend_q;
    logic [12:0] int_cnt_q, int_cnt_d;
    logic int_start;
    logic [12:0] low_len_q;
    logic [14:0] igood_wait_q;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == CTRL_ADDR) || (a == LIMIT_PIN_ADDR) ||
            (a == VLIM_ADDR) || (a == STAT_ADDR) || (a == EFF_ADDR);
    endfunction : addr_hit

    function automatic logic [6:0] lim_min(input logic [6:0] a,
                                           input logic [6:0] b);
        lim_min = (a < b) ? a : b;
    endfunction : lim_min

    // Two-flop synchroniser for comparator levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {vbus_uvlo_ok, vbus_sleep_ok, vbus_boost_sleep_ok,
                boost_mode, bat_above_dpl, bat_ocp, ship_exit, vbus_ovp_ok,
                vbus_min_ok, dcd_contact, primary_det, secondary_det,
                dp_2p7, dp_2p0, dp_1p2, dm_2p7, dm_2p0, dm_1p2, select_pin};
            sync2_q <= sync1_q;
        end
    end

    assign {uvlo_ok, sleep_ok, bsleep_ok, boost, bat_dpl, ocp, ship,
        ovp_ok, min_ok, dcd, prim, sec, dpw, dmw, psel_pin} = sync2_q;

    // Millisecond tick divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 15'h0001;
        end
    end

    assign tick = (tick_cnt_q >= 15'(TICK_CYCLES - 1));

    // Step timer, restarted on every state change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q <= '0;
        end else if (st_d != st_q) begin
            ms_q <= '0;
        end else if (tick && ms_q != 11'h7ff) begin
            ms_q <= ms_q + 11'h001;
        end
    end

    assign bias_cond = uvlo_ok && !ctrl_q[C_HIZ] &&
        (boost ? bsleep_ok : sleep_ok);

    // Power-up sequence
    always_comb begin
        st_d = st_q;
        qual_pass = 1'b0;
        qual_fail = 1'b0;
        det_done = 1'b0;
        det_type = TYP_NONE;
        det_lim = limit_pin_q;
        vlim_set = 1'b0;
        if (!bias_cond) begin
            st_d = ST_HIZ;
        end else begin
            case (st_q)
                ST_HIZ: st_d = ST_BIAS_REGULATOR;
                ST_BIAS_REGULATOR: begin
                    if (ms_q >= 11'(T_BIAS_REGULATOR_MS)) st_d = ST_QUAL;
                end
                ST_QUAL: begin
                    if (!ovp_ok || !min_ok) begin
                        qual_fail = 1'b1;
                        st_d = ST_RETRY;
                    end else if (ms_q >= 11'(T_BADSRC_MS)) begin
                        qual_pass = 1'b1;
                        if (ctrl_q[C_AUTO] || ctrl_q[C_FORCE]) begin
                            st_d = ST_DETECT;
                        end else begin
                            st_d = ST_VLIM;
                        end
                    end
                end
                ST_RETRY: begin
                    if (ms_q >= 11'(T_RETRY_MS)) st_d = ST_QUAL;
                end
                ST_DETECT: begin
                    if (ctrl_q[C_SELPIN]) begin
                        det_done = 1'b1;
                        det_type = psel_pin ? TYP_SDP : TYP_CDP;
                        det_lim = psel_pin ? LIM_500MA : LIM_3A25;
                    end else if (dcd) begin
                        if (!prim) begin
                            det_done = 1'b1;
                            det_type = TYP_SDP;
                            det_lim = LIM_500MA;
                        end else if (!sec) begin
                            det_done = 1'b1;
                            det_type = TYP_CDP;
                            det_lim = LIM_1A5;
                        end else if (ctrl_q[C_HVA] || ctrl_q[C_HVB]) begin
                            st_d = ST_HANDSHAKE;
                        end else begin
                            det_done = 1'b1;
                            det_type = TYP_DCP;
                            det_lim = LIM_3A25;
                        end
                    end else if (ms_q >= 11'(T_DCD_MS)) begin
                        det_done = 1'b1;
                        det_type = TYP_DIV;
                        if (dpw[2] && dmw[1]) det_lim = LIM_2A1;
                        else if (dpw[0] && dmw[0]) det_lim = LIM_2A;
                        else if (dpw[1] && dmw[2]) det_lim = LIM_1A;
                        else if (dpw[2] && dmw[2]) det_lim = LIM_2A4;
                        else begin
                            det_type = TYP_UNK;
                            det_lim = LIM_500MA;
                        end
                    end
                end
                ST_HANDSHAKE: begin
                    if (!ctrl_q[C_HVA] && !ctrl_q[C_HVB]) begin
                        det_done = 1'b1;
                        det_type = TYP_DCP;
                        det_lim = LIM_3A25;
                    end else if (ms_q >= 11'(T_HVHS_MS)) begin
                        det_done = 1'b1;
                        det_type = TYP_HV;
                        det_lim = LIM_1A5;
                    end
                end
                ST_VLIM: begin
                    vlim_set = 1'b1;
                    st_d = ST_RUN;
                end
                ST_RUN: begin
                    if (ctrl_q[C_FORCE]) st_d = ST_DETECT;
                end
                default: st_d = ST_HIZ;
            endcase
            if (det_done) st_d = ST_VLIM;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_HIZ;
        end else begin
            st_q <= st_d;
        end
    end

    // Power path outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_regulator_en <= 1'b0;
            test_load_en <= 1'b0;
            converter_en <= 1'b0;
            dp_sink_en <= 1'b0;
            dp_src_en <= 1'b0;
            dm_sink_en <= 1'b0;
            dm_src_en <= 1'b0;
        end else begin
            bias_regulator_en <= !(st_d == ST_HIZ || st_d == ST_BIAS_REGULATOR);
            test_load_en <= (st_d == ST_QUAL);
            converter_en <= (st_d == ST_RUN);
            dp_sink_en <= (st_d == ST_HANDSHAKE) && ctrl_q[C_REQ12];
            dm_src_en <= (st_d == ST_HANDSHAKE) && ctrl_q[C_REQ12];
            dp_src_en <= (st_d == ST_HANDSHAKE) && !ctrl_q[C_REQ12];
            dm_sink_en <= (st_d == ST_HANDSHAKE) && !ctrl_q[C_REQ12];
        end
    end

    // Battery switch and its disable flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bat_dis_q <= 1'b0;
            uvlo_prev_q <= 1'b0;
            battery_switch_on <= 1'b0;
        end else begin
            uvlo_prev_q <= uvlo_ok;
            if (ocp) begin
                bat_dis_q <= 1'b1;
            end else if ((uvlo_ok && !uvlo_prev_q) || ship) begin
                bat_dis_q <= 1'b0;
            end
            battery_switch_on <= bat_dpl && !ocp && !bat_dis_q;
        end
    end

    // APB register file
    assign wr = psel && penable && pwrite && addr_hit(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr && paddr == CTRL_ADDR) begin
            ctrl_q <= pwdata[7:0];
            if (!pwdata[C_FORCE] && det_done) ctrl_q[C_FORCE] <= 1'b0;
        end else if (det_done) begin
            ctrl_q[C_FORCE] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_pin_q <= LIMIT_PIN_RST;
        end else if (wr && paddr == LIMIT_PIN_ADDR) begin
            limit_pin_q <= pwdata[6:0];
        end else if (det_done) begin
            limit_pin_q <= det_lim;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vlim_q <= VLIM_RST;
        end else if (wr && paddr == VLIM_ADDR && ctrl_q[C_FABS]) begin
            vlim_q <= pwdata[7:0];
        end else if (vlim_set && !ctrl_q[C_FABS]) begin
            if (vlim_auto < VLIM_MIN) vlim_q <= VLIM_MIN;
            else if (vlim_auto > VLIM_MAX) vlim_q <= VLIM_MAX;
            else vlim_q <= vlim_auto;
        end
    end

    // Detection results and status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_type_q <= TYP_NONE;
            input_good_q <= 1'b0;
            power_good_q <= 1'b0;
            det_stat_q <= 1'b0;
            power_good_pin_n <= 1'b1;
        end else begin
            if (qual_pass) input_good_q <= 1'b1;
            else if (qual_fail) input_good_q <= 1'b0;
            if (det_done) begin
                src_type_q <= det_type;
                det_stat_q <= 1'b1;
                power_good_q <= 1'b1;
                if (ctrl_q[C_SELPIN]) power_good_pin_n <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            eff_current_limit <= LIMIT_PIN_RST;
        end else begin
            eff_current_limit <= lim_min(limit_pin_q, limit_pin_code);
            if (rd_setup) begin
                prdata <= '0;
                case (paddr)
                    CTRL_ADDR: prdata[7:0] <= ctrl_q;
                    LIMIT_PIN_ADDR: prdata[6:0] <= limit_pin_q;
                    VLIM_ADDR: prdata[7:0] <= vlim_q;
                    STAT_ADDR: prdata[9:0] <= {converter_en,
                        bias_regulator_en, st_q == ST_HIZ, bat_dis_q,
                        det_stat_q, power_good_q, input_good_q,
                        src_type_q};
                    EFF_ADDR: prdata[6:0] <= eff_current_limit;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    assign input_voltage_limit = vlim_q;

    // Interrupt pulse queue: low window then equal high gap
    assign int_start = (int_cnt_q == '0) && (pend_q != 2'h0);

    always_comb begin
        int_cnt_d = int_cnt_q;
        if (int_start) int_cnt_d = 13'(2 * INT_CYC);
        else if (int_cnt_q != '0) int_cnt_d = int_cnt_q - 13'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 2'h0;
            int_cnt_q <= '0;
            int_n <= 1'b1;
        end else begin
            if ((qual_pass || det_done || vlim_set) && !int_start) begin
                if (pend_q != 2'h3) pend_q <= pend_q + 2'h1;
            end else if (!(qual_pass || det_done || vlim_set) && int_start) begin
                pend_q <= pend_q - 2'h1;
            end
            int_cnt_q <= int_cnt_d;
            int_n <= !(int_cnt_d > 13'(INT_CYC));
        end
    end

    // Pulse length helper for checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_len_q <= '0;
        end else if (!int_n) begin
            low_len_q <= low_len_q + 13'h0001;
        end else begin
            low_len_q <= '0;
        end
    end

    // Cycles from a passed source to its interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            igood_wait_q <= '0;
        end else if (qual_pass) begin
            igood_wait_q <= 15'h0001;
        end else if (!int_n) begin
            igood_wait_q <= '0;
        end else if (igood_wait_q != '0) begin
            igood_wait_q <= igood_wait_q + 15'h0001;
        end
    end

    int_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(int_n) |-> low_len_q == 13'(INT_CYC))
        else $error("interrupt pulse width wrong");
    bias_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !bias_cond |=> !bias_regulator_en)
        else $error("bias regulator on without its conditions");
    bias_regulator_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bias_regulator_en) |-> $past(st_q) == ST_BIAS_REGULATOR &&
        ms_q == 11'h000)
        else $error("bias regulator on before delay");
    batt_ocp_a: assert property (@(posedge pclk) disable iff (!presetn)
        ocp |=> !battery_switch_on && bat_dis_q)
        else $error("battery switch not cut on overcurrent");
    igood_int_a: assert property (@(posedge pclk) disable iff (!presetn)
        qual_pass |=> input_good_q)
        else $error("input good not set");
    igood_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        igood_wait_q < 15'(8 * INT_CYC))
        else $error("input good not reported");
    skip_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        qual_pass && !ctrl_q[C_AUTO] && !ctrl_q[C_FORCE] &&
        !(wr && paddr == LIMIT_PIN_ADDR) |=> $stable(limit_pin_q) &&
        $stable(src_type_q))
        else $error("results changed with detection off");
    force_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        det_done && !(wr && paddr == CTRL_ADDR) |=> !ctrl_q[C_FORCE] &&
        det_stat_q && limit_pin_q == ($past(wr && paddr == LIMIT_PIN_ADDR) ?
        $past(pwdata[6:0]) : $past(det_lim)))
        else $error("force bit not cleared or result not loaded");
    eff_min_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 eff_current_limit == lim_min($past(limit_pin_q),
        $past(limit_pin_code)))
        else $error("effective limit not the minimum");
    hv_lines_a: assert property (@(posedge pclk) disable iff (!presetn)
        dp_sink_en |-> dm_src_en && !dp_src_en && !dm_sink_en)
        else $error("handshake line drive inconsistent");
    conv_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(converter_en) |-> $past(st_q) == ST_VLIM)
        else $error("converter started without voltage limit step");

endmodule : cpsd_core
`default_nettype wire

/* cpsd_port_model.sv */
/* Model of the port or adapter on the D+/D- side.
   Assumes the bench picks the port kind on mode. */
`timescale 1ns/1ns
`default_nettype none
module cpsd_port_model (
    // Kind: 0 none, 1 SDP, 2 CDP, 3 DCP, 4 divider
    input wire logic [2:0] mode,
    // Comparator levels
    output logic dcd_contact,
    output logic primary_det,
    output logic secondary_det,
    output logic [5:0] lvl
);
    assign dcd_contact = mode inside {3'h1, 3'h2, 3'h3};
    assign primary_det = mode inside {3'h2, 3'h3};
    assign secondary_det = mode == 3'h3;
    assign lvl = (mode == 3'h4) ? 6'h24 : 6'h00;
endmodule : cpsd_port_model
`default_nettype wire

/* tb_charger_powerup_source_detect.sv */
/* Self-checking bench for cpsd_core.
   Assumes a 4-cycle tick and the port model on D+/D-. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, x) begin n_checks++; if ((a) !== (x)) begin err_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, x); end end
module tb_charger_powerup_source_detect
    import cpsd_pkg::*;
();
    localparam int TK = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vbus_uvlo_ok = 1'b0, vbus_sleep_ok = 1'b0;
    logic bat_ocp = 1'b0, vbus_min_ok = 1'b0, zero = 1'b0, one = 1'b1;
    logic [7:0] paddr = 8'h00, vlim_auto = 8'h50;
    logic [31:0] pwdata = 32'h0, prdata, r, st = 32'd49, t;
    logic [6:0] limit_pin_code = 7'h7f, eff_current_limit, v, lp;
    logic [7:0] input_voltage_limit;
    logic [5:0] lvl;
    logic [2:0] mode = 3'h0;
    logic pready, pslverr, e, bias_regulator_en, battery_switch_on;
    logic test_load_en, converter_en, int_n, power_good_pin_n;
    logic dcd_contact, primary_det, secondary_det;
    logic dp_sink_en, dp_src_en, dm_sink_en, dm_src_en, select_pin = 1'b0;
    int err_count = 0, n_checks = 0, n_int = 0, cyc = 0;
    cpsd_core #(.TICK_CYCLES(TK)) cpsd_core_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .vbus_uvlo_ok, .vbus_sleep_ok, .vbus_boost_sleep_ok(zero),
        .boost_mode(zero), .bat_above_dpl(one), .bat_ocp, .ship_exit(zero),
        .vbus_ovp_ok(one), .vbus_min_ok, .dcd_contact, .primary_det,
        .secondary_det, .dp_2p7(lvl[5]), .dp_2p0(lvl[4]), .dp_1p2(lvl[3]),
        .dm_2p7(lvl[2]), .dm_2p0(lvl[1]), .dm_1p2(lvl[0]), .select_pin,
        .limit_pin_code, .vlim_auto, .bias_regulator_en, .battery_switch_on,
        .test_load_en, .converter_en, .dp_sink_en, .dp_src_en,
        .dm_sink_en, .dm_src_en, .eff_current_limit,
        .input_voltage_limit, .int_n, .power_good_pin_n);
    cpsd_port_model cpsd_port_model_inst (.mode, .dcd_contact,
        .primary_det, .secondary_det, .lvl);
    always #20 pclk = ~pclk;
    always @(negedge int_n) n_int++;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs
    function automatic logic [6:0] lmin(logic [6:0] a, logic [6:0] b);
        return (a < b) ? a : b;
    endfunction : lmin
    task automatic w(int n);
        repeat (n) @(posedge pclk);
    endtask : w
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask : rd
    task automatic res(logic [2:0] ty, logic [6:0] l);
        apb(1'b0, STAT_ADDR, 32'h0);
        `CHK(r[2:0], ty)
        rd(LIMIT_PIN_ADDR, {25'h0, l});
    endtask : res
    task automatic wait_force();
        apb(1'b0, CTRL_ADDR, 32'h0);
        for (int i = 0; i < 3000 && r[C_FORCE] !== 1'b0; i++)
            apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(r[C_FORCE], 1'b0)
    endtask : wait_force
    task automatic wc(int n);
        for (int i = 0; i < n && converter_en !== 1'b1; i++) w(1);
        `CHK(converter_en, 1'b1)
    endtask : wc
    task automatic report_and_stop();
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        w(2);
        presetn <= 1'b1;
        w(1);
        rd(CTRL_ADDR, {24'h0, CTRL_RST});
        rd(LIMIT_PIN_ADDR, {25'h0, LIMIT_PIN_RST});
        rd(VLIM_ADDR, {24'h0, VLIM_RST});
        rd(8'h14, 32'h0);
        `CHK(e, 1'b1)
        `CHK(battery_switch_on, 1'b1)
        `CHK(bias_regulator_en, 1'b0)
        bat_ocp <= 1'b1;
        w(4);
        bat_ocp <= 1'b0;
        w(4);
        `CHK(battery_switch_on, 1'b0)
        apb(1'b0, STAT_ADDR, 32'h0);
        `CHK(r[S_BATDIS], 1'b1)
        mode <= 3'h1;
        apb(1'b1, CTRL_ADDR, 32'h01);
        vbus_uvlo_ok <= 1'b1;
        vbus_sleep_ok <= 1'b1;
        w(200 * TK);
        `CHK(bias_regulator_en, 1'b0)
        for (int i = 0; i < 24 * TK && bias_regulator_en !== 1'b1; i++) w(1);
        `CHK(bias_regulator_en, 1'b1)
        `CHK(test_load_en, 1'b1)
        w(100 * TK);
        vbus_min_ok <= 1'b1;
        w(1500 * TK);
        `CHK(converter_en, 1'b0)
        wc(4000);
        rd(STAT_ADDR, 32'h339);
        rd(LIMIT_PIN_ADDR, {25'h0, LIM_500MA});
        `CHK(power_good_pin_n, 1'b1)
        w(12000);
        `CHK(n_int, 3)
        vlim_auto <= 8'h30;
        mode <= 3'h2;
        apb(1'b1, CTRL_ADDR, 32'h03);
        wait_force();
        res(TYP_CDP, LIM_1A5);
        mode <= 3'h4;
        apb(1'b1, CTRL_ADDR, 32'h03);
        wait_force();
        res(TYP_DIV, LIM_2A4);
        mode <= 3'h3;
        apb(1'b1, CTRL_ADDR, 32'h47);
        w(20);
        `CHK(dp_sink_en & dm_src_en, 1'b1)
        `CHK(dp_src_en | dm_sink_en, 1'b0)
        wait_force();
        res(TYP_HV, LIM_1A5);
        apb(1'b1, CTRL_ADDR, 32'h83);
        wait_force();
        res(TYP_CDP, LIM_3A25);
        `CHK(power_good_pin_n, 1'b0)
        for (int i = 0; i < 4; i++) begin
            t = xs();
            v = t[6:0];
            lp = t[14:8];
            limit_pin_code <= lp;
            apb(1'b1, LIMIT_PIN_ADDR, {25'h0, v});
            w(3);
            `CHK(eff_current_limit, lmin(v, lp))
        end
        apb(1'b1, VLIM_ADDR, 32'h60);
        rd(VLIM_ADDR, 32'h30);
        apb(1'b1, CTRL_ADDR, 32'h20);
        apb(1'b1, VLIM_ADDR, 32'h60);
        `CHK(input_voltage_limit, 8'h60)
        vbus_uvlo_ok <= 1'b0;
        w(5);
        `CHK(bias_regulator_en, 1'b0)
        vbus_uvlo_ok <= 1'b1;
        mode <= 3'h1;
        wc(4000);
        res(TYP_CDP, v);
        apb(1'b1, CTRL_ADDR, 32'h30);
        w(1);
        `CHK(bias_regulator_en, 1'b0)
        apb(1'b0, STAT_ADDR, 32'h0);
        `CHK(r[S_HIZST], 1'b1)
        report_and_stop();
    end
endmodule : tb_charger_powerup_source_detect
`default_nettype wire
